// >>> design/tmb_top.sv
// How it works
// - headers need render client code, group, opcode
// - header bit 16 picks texture map
// - fields load only when mask bit set
// - bit 10 enables anisotropic filtering
// - mip mode 7:6 under mask 9
// - mag bit3/mask5, min bit0/mask2
// - max mip level 12:5 under mask 13
// - nonzero max level clamps LOD from below
// - min level 3:0 clamps LOD from above
// - signed S2.4 bias added to LOD
// - palette packet brings 256 entries in order
// - colour stage select bits 21:20
// - bit 18 routes result current/accumulator
// - argument codes pick eight colour sources
// - replicate alpha and invert per argument
// - colour operation codes and their math
// - op zero stops this and later stages
// - signed add excess 128; lerp math
// - colour stage enable also runs alpha
// - alpha stages set by group 01h
// - anisotropic bit needs mask 12
`include "tmb_defines.svh"
`default_nettype none
module tmb_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	output logic [31:0] result_o,
	output logic [7:0] lod_o,
	output logic busy_o
);
	////////////////////////////////////////////////////////////////
	tmb_pkg::tmb_st_type s_reg;
	tmb_pkg::tmb_st_type s_next;
	tmb_pkg::tmb_stg_type st;
	logic [15:0] pal_mem [256];
	logic pal_we;
	logic req;
	logic wr;
	logic cmd_ok;
	logic dec_filt;
	logic lod_wr;
	logic [31:0] arg1;
	logic [31:0] arg2;
	logic [31:0] alu_res;
	logic [31:0] new_cur;
	logic [31:0] asrc1;
	logic [31:0] asrc2;
	logic [31:0] csrc1;
	logic [31:0] csrc2;
	logic [31:0] aterm;

	// colour source by argument code
	function automatic logic [31:0] csel(input logic [2:0] c, input tmb_pkg::tmb_st_type s);
		case (c)
			`TMB_ARG_ONES: csel = 32'hFFFFFFFF;
			`TMB_ARG_FAC: csel = s.src[`TMB_SRC_FAC];
			`TMB_ARG_ACC: csel = s.acc;
			`TMB_ARG_ITER: csel = s.src[`TMB_SRC_ITER];
			`TMB_ARG_SPEC: csel = s.src[`TMB_SRC_SPEC];
			`TMB_ARG_CUR: csel = s.cur;
			`TMB_ARG_TEX0: csel = s.src[`TMB_SRC_TEX0];
			default: csel = s.src[`TMB_SRC_TEX1];
		endcase
	endfunction

	// blend term for lerp operations, per lane
	function automatic logic [31:0] tsel(input logic [4:0] op, input tmb_pkg::tmb_st_type s);
		case (op)
			`TMB_OP_LERPI: tsel = {4{s.src[`TMB_SRC_ITER][31:24]}};
			`TMB_OP_LERPF: tsel = {4{s.src[`TMB_SRC_FAC][31:24]}};
			`TMB_OP_LERPA0: tsel = {4{s.src[`TMB_SRC_TEX0][31:24]}};
			`TMB_OP_LERPA1: tsel = {4{s.src[`TMB_SRC_TEX1][31:24]}};
			`TMB_OP_LERPC0: tsel = s.src[`TMB_SRC_TEX0];
			`TMB_OP_LERPC1: tsel = s.src[`TMB_SRC_TEX1];
			default: tsel = 32'h0;
		endcase
	endfunction

	// argument with alpha replicate and invert applied
	function automatic logic [31:0] carg(input logic [2:0] c, input logic rep, input logic inv,
			input tmb_pkg::tmb_st_type s);
		logic [31:0] v;
		v = csel(c, s);
		if (rep) begin
			v = {4{v[31:24]}};
		end
		return inv ? ~v : v;
	endfunction

	function automatic logic a_op_ok(input logic [4:0] op);
		return op inside {[`TMB_OP_SEL1:`TMB_OP_LERPI], `TMB_OP_LERPF, `TMB_OP_LERPA0, `TMB_OP_LERPA1};
	endfunction

	function automatic logic c_op_ok(input logic [4:0] op);
		return a_op_ok(op) || op inside {`TMB_OP_OFF, [`TMB_OP_LERPC0:`TMB_OP_SUB]};
	endfunction

	// alpha arguments 0h, 2h and 4h are reserved
	function automatic logic a_arg_ok(input logic [2:0] c);
		return c[0] || c == `TMB_ARG_TEX0;
	endfunction

	// bias, then floor from max level, then ceiling from min level
	function automatic logic [7:0] lod_calc(input tmb_pkg::tmb_map_type m, input logic [7:0] raw);
		logic [9:0] v;
		logic [7:0] r;
		v = {2'b00, raw} + {{3{m.bias[6]}}, m.bias};
		r = v[9] ? 8'h00 : (v[8] ? 8'hFF : v[7:0]);
		if (m.maxl != 8'h00 && r < m.maxl) begin
			r = m.maxl;
		end
		if (r > {m.minl, 4'h0}) begin
			r = {m.minl, 4'h0};
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////
	// bus request qualification and header check
	assign req = cyc_i && stb_i && !s_reg.ack;
	assign wr = req && we_i && sel_i == 4'hF;
	assign cmd_ok = wr && adr_i == `TMB_A_CMD && !s_reg.pal_busy
		&& dat_i[`TMB_R_CLIENT] == `TMB_CLIENT_RENDER;
	assign dec_filt = cmd_ok && dat_i[`TMB_R_GROUP] == `TMB_GRP_SHORT
		&& dat_i[`TMB_R_OP5] == `TMB_OP_FILTER;
	assign lod_wr = wr && adr_i == `TMB_A_LODIN;

	// stage operands for the step in flight
	assign st = s_reg.stg[s_reg.sidx];
	assign asrc1 = csel(st.aa1, s_reg);
	assign asrc2 = csel(st.aa2, s_reg);
	assign csrc1 = carg(st.ca1, st.rep1, st.inv1, s_reg);
	assign csrc2 = carg(st.ca2, st.rep2, st.inv2, s_reg);
	assign aterm = tsel(st.aop, s_reg);
	assign arg1 = {asrc1[31:24] ^ {8{st.ainv1}}, csrc1[23:0]};
	assign arg2 = {asrc2[31:24] ^ {8{st.ainv2}}, csrc2[23:0]};
	assign new_cur = st.dst ? s_reg.cur : alu_res;

	tmb_blend_alu u_alu (
		.arg1_i(arg1),
		.arg2_i(arg2),
		.cterm_i(tsel(st.cop, s_reg)),
		.aterm_i(aterm[31:24]),
		.cop_i(st.cop),
		.aop_i(st.aop),
		.res_o(alu_res)
	);

	////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic m;
		logic [1:0] si;
		m = dat_i[`TMB_B_MAP];
		si = dat_i[`TMB_R_STG];
		s_next = s_reg;
		pal_we = 1'b0;
		s_next.ack = req;
		s_next.dat = 32'h0;
		// register reads; unmapped addresses read zero
		if (req && !we_i) begin
			case (adr_i)
				`TMB_A_STATUS: s_next.dat = {16'h0, s_reg.pal_cnt, 6'h0, s_reg.run, s_reg.pal_busy};
				`TMB_A_MAP0: s_next.dat = {8'h0, s_reg.map[0]};
				`TMB_A_MAP1: s_next.dat = {8'h0, s_reg.map[1]};
				`TMB_A_STG0: s_next.dat = {3'h0, s_reg.stg[0]};
				`TMB_A_STG1: s_next.dat = {3'h0, s_reg.stg[1]};
				`TMB_A_STG2: s_next.dat = {3'h0, s_reg.stg[2]};
				`TMB_A_PIDX: s_next.dat = {24'h0, s_reg.pal_idx};
				`TMB_A_PDATA: s_next.dat = {16'h0, pal_mem[s_reg.pal_idx]};
				`TMB_A_CUR: s_next.dat = s_reg.cur;
				`TMB_A_ACC: s_next.dat = s_reg.acc;
				`TMB_A_LODOUT: s_next.dat = {24'h0, s_reg.lod};
				default: begin
					if (adr_i >= `TMB_A_SRC0 && adr_i <= `TMB_A_SRC4) begin
						s_next.dat = s_reg.src[3'(adr_i[7:2] - `TMB_A_SRC0 / 4)];
					end
				end
			endcase
		end
		// palette body: every command dword goes to the next entry
		if (wr && adr_i == `TMB_A_CMD && s_reg.pal_busy) begin
			pal_we = 1'b1;
			s_next.pal_cnt = s_reg.pal_cnt + 8'h01;
			if (s_reg.pal_cnt == `TMB_PAL_LAST) begin
				s_next.pal_busy = 1'b0;
			end
		end
		// short state group: filter and level-of-detail
		if (cmd_ok && dat_i[`TMB_R_GROUP] == `TMB_GRP_SHORT) begin
			case (dat_i[`TMB_R_OP5])
				`TMB_OP_FILTER: begin
					if (dat_i[`TMB_B_ANI_M]) begin
						s_next.map[m].ani = dat_i[`TMB_B_ANI];
					end
					if (dat_i[`TMB_B_MIP_M] && !dat_i[`TMB_B_MIP_HI]) begin
						s_next.map[m].mip = dat_i[`TMB_R_MIP];
					end
					if (dat_i[`TMB_B_MAG_M]) begin
						s_next.map[m].mag = dat_i[`TMB_B_MAG];
					end
					if (dat_i[`TMB_B_MIN_M]) begin
						s_next.map[m].min = dat_i[`TMB_B_MIN];
					end
				end
				`TMB_OP_LODLIM: begin
					if (dat_i[`TMB_B_MAXL_M]) begin
						s_next.map[m].maxl = dat_i[`TMB_R_MAXL];
					end
					if (dat_i[`TMB_B_MINL_M] && dat_i[`TMB_R_MINL] <= `TMB_MINL_MAX) begin
						s_next.map[m].minl = dat_i[`TMB_R_MINL];
					end
				end
				`TMB_OP_LODCTL: begin
					if (dat_i[`TMB_B_BIAS_M]) begin
						s_next.map[m].bias = dat_i[`TMB_R_BIAS];
					end
				end
				default: begin
				end
			endcase
		end
		// palette load header
		if (cmd_ok && dat_i[`TMB_R_GROUP] == `TMB_GRP_MWNP && dat_i[`TMB_R_OP8] == `TMB_OP_PAL
				&& dat_i[`TMB_R_LEN] == `TMB_PAL_LEN) begin
			s_next.pal_busy = 1'b1;
			s_next.pal_cnt = 8'h00;
		end
		// colour stage setup; stage index 3 is ignored
		if (cmd_ok && dat_i[`TMB_R_GROUP] == `TMB_GRP_CBLEND && si <= `TMB_STG_LAST) begin
			if (dat_i[`TMB_B_DST_M]) begin
				s_next.stg[si].dst = dat_i[`TMB_B_DST];
			end
			if (dat_i[`TMB_B_CA1_M]) begin
				s_next.stg[si].ca1 = dat_i[`TMB_R_CA1];
				s_next.stg[si].rep1 = dat_i[`TMB_B_REP1];
				s_next.stg[si].inv1 = dat_i[`TMB_B_INV1];
			end
			if (dat_i[`TMB_B_CA2_M]) begin
				s_next.stg[si].ca2 = dat_i[`TMB_R_ARG2];
				s_next.stg[si].rep2 = dat_i[`TMB_B_REP2];
				s_next.stg[si].inv2 = dat_i[`TMB_B_INV2];
			end
			if (dat_i[`TMB_B_OP_M] && c_op_ok(dat_i[`TMB_R_OPF])) begin
				s_next.stg[si].cop = dat_i[`TMB_R_OPF];
			end
		end
		// alpha stage setup
		if (cmd_ok && dat_i[`TMB_R_GROUP] == `TMB_GRP_ABLEND && si <= `TMB_STG_LAST) begin
			if (dat_i[`TMB_B_AA1_M] && a_arg_ok(dat_i[`TMB_R_AA1])) begin
				s_next.stg[si].aa1 = dat_i[`TMB_R_AA1];
				s_next.stg[si].ainv1 = dat_i[`TMB_B_AINV1];
			end
			if (dat_i[`TMB_B_AA2_M] && a_arg_ok(dat_i[`TMB_R_ARG2])) begin
				s_next.stg[si].aa2 = dat_i[`TMB_R_ARG2];
				s_next.stg[si].ainv2 = dat_i[`TMB_B_AINV2];
			end
			if (dat_i[`TMB_B_OP_M] && a_op_ok(dat_i[`TMB_R_OPF])) begin
				s_next.stg[si].aop = dat_i[`TMB_R_OPF];
			end
		end
		// plain register writes
		if (wr && adr_i >= `TMB_A_SRC0 && adr_i <= `TMB_A_SRC4 && adr_i[1:0] == 2'b00) begin
			s_next.src[3'(adr_i[7:2] - `TMB_A_SRC0 / 4)] = dat_i;
		end
		if (wr && adr_i == `TMB_A_PIDX) begin
			s_next.pal_idx = dat_i[7:0];
		end
		if (lod_wr) begin
			s_next.lod = lod_calc(s_reg.map[dat_i[8]], dat_i[7:0]);
		end
		// blend walk over the three stages
		case (s_reg.run)
			tmb_pkg::TMB_IDLE: begin
				if (wr && adr_i == `TMB_A_RUN) begin
					s_next.run = tmb_pkg::TMB_RUN;
					s_next.sidx = 2'h0;
					s_next.cur = s_reg.src[`TMB_SRC_ITER];
					s_next.acc = 32'h0;
				end
			end
			tmb_pkg::TMB_RUN: begin
				if (st.cop == `TMB_OP_OFF) begin
					s_next.run = tmb_pkg::TMB_IDLE;
					s_next.result = s_reg.cur;
				end else begin
					if (st.dst) begin
						s_next.acc = alu_res;
					end else begin
						s_next.cur = alu_res;
					end
					if (s_reg.sidx == `TMB_STG_LAST) begin
						s_next.run = tmb_pkg::TMB_IDLE;
						s_next.result = new_cur;
					end else begin
						s_next.sidx = s_reg.sidx + 2'h1; // index never leaves the three stages
					end
				end
			end
			default: s_next.run = tmb_pkg::TMB_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.map[0].minl <= `TMB_MINL_RST;
			s_reg.map[1].minl <= `TMB_MINL_RST;
			s_reg.map[0].bias <= `TMB_BIAS_RST;
			s_reg.map[1].bias <= `TMB_BIAS_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// palette storage, entries in arrival order
	always_ff @(posedge clk_i) begin
		if (pal_we) begin
			pal_mem[s_reg.pal_cnt] <= dat_i[15:0];
		end
	end

	assign ack_o = s_reg.ack;
	assign dat_o = s_reg.dat;
	assign result_o = s_reg.result;
	assign lod_o = s_reg.lod;
	assign busy_o = s_reg.run;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_wb_ack_once: assert property (s_reg.ack |=> !s_reg.ack) else $error("ack longer than one cycle");
	a_wb_ack_next: assert property (req |=> s_reg.ack) else $error("request not acknowledged");
	a_pal_start: assert property ($rose(s_reg.pal_busy) |-> s_reg.pal_cnt == 8'h00)
		else $error("palette load not started at entry 0");
	a_mip_hold_mask: assert property (dec_filt && !dat_i[`TMB_B_MIP_M] && !dat_i[`TMB_B_MAP]
		|=> $stable(s_reg.map[0].mip)) else $error("mip mode changed without mask");
	a_ani_load_map: assert property (dec_filt && dat_i[`TMB_B_ANI_M] && dat_i[`TMB_B_MAP]
		|=> s_reg.map[1].ani == $past(dat_i[`TMB_B_ANI])) else $error("anisotropic bit not loaded");
	a_mip_no_rsvd: assert property (!s_reg.map[0].mip[1] && !s_reg.map[1].mip[1])
		else $error("reserved mip mode stored");
	a_lod_clamp_map: assert property (lod_wr && !dat_i[8] |=> s_reg.lod <= {s_reg.map[0].minl, 4'h0}
		&& (s_reg.map[0].maxl == 8'h00 || s_reg.map[0].maxl > {s_reg.map[0].minl, 4'h0}
		|| s_reg.lod >= s_reg.map[0].maxl)) else $error("lod outside limits");
	a_run_stop_off: assert property (s_reg.run == tmb_pkg::TMB_RUN && st.cop == `TMB_OP_OFF
		|=> s_reg.run == tmb_pkg::TMB_IDLE && $stable(s_reg.cur)) else $error("disabled stage ran");
	a_run_bounded: assert property ($rose(busy_o) |-> ##[1:3] !busy_o) else $error("blend walk too long");
	a_acc_keeps_cur: assert property (s_reg.run == tmb_pkg::TMB_RUN && st.cop != `TMB_OP_OFF && st.dst
		|=> $stable(s_reg.cur)) else $error("accumulator write touched current");

	c_pal_done: cover property ($fell(s_reg.pal_busy));
	c_run_full: cover property (s_reg.run == tmb_pkg::TMB_RUN && s_reg.sidx == `TMB_STG_LAST);
	c_run_cut: cover property (s_reg.run == tmb_pkg::TMB_RUN && st.cop == `TMB_OP_OFF);
	c_lod_calc: cover property (lod_wr);
endmodule
`default_nettype wire

// >>> design/tmb_defines.svh
`ifndef TMB_DEFINES_SVH
`define TMB_DEFINES_SVH
// instruction header fields
`define TMB_R_CLIENT 31:29
`define TMB_R_GROUP 28:24
`define TMB_R_OP5 23:19
`define TMB_R_OP8 23:16
`define TMB_R_LEN 15:0
`define TMB_CLIENT_RENDER 3'h3
`define TMB_GRP_SHORT 5'h1C
`define TMB_GRP_MWNP 5'h1D
`define TMB_GRP_CBLEND 5'h00
`define TMB_GRP_ABLEND 5'h01
`define TMB_OP_FILTER 5'h02
`define TMB_OP_LODLIM 5'h03
`define TMB_OP_LODCTL 5'h04
`define TMB_OP_PAL 8'h82
`define TMB_PAL_LEN 16'h00FF
`define TMB_PAL_LAST 8'hFF
// map state fields
`define TMB_B_MAP 16
`define TMB_B_ANI_M 12
`define TMB_B_ANI 10
`define TMB_B_MIP_M 9
`define TMB_B_MIP_HI 7
`define TMB_R_MIP 7:6
`define TMB_B_MAG_M 5
`define TMB_B_MAG 3
`define TMB_B_MIN_M 2
`define TMB_B_MIN 0
`define TMB_B_MAXL_M 13
`define TMB_R_MAXL 12:5
`define TMB_B_MINL_M 4
`define TMB_R_MINL 3:0
`define TMB_MINL_MAX 4'hA
`define TMB_MINL_RST 4'hA
`define TMB_B_BIAS_M 7
`define TMB_R_BIAS 6:0
`define TMB_BIAS_RST 7'h00
// blend stage fields
`define TMB_R_STG 21:20
`define TMB_STG_LAST 2'h2
`define TMB_B_DST_M 19
`define TMB_B_DST 18
`define TMB_B_CA1_M 17
`define TMB_R_CA1 16:14
`define TMB_B_REP1 13
`define TMB_B_INV1 12
`define TMB_B_CA2_M 11
`define TMB_R_ARG2 10:8
`define TMB_B_REP2 7
`define TMB_B_INV2 6
`define TMB_B_OP_M 5
`define TMB_R_OPF 4:0
`define TMB_B_AA1_M 18
`define TMB_R_AA1 17:15
`define TMB_B_AINV1 13
`define TMB_B_AA2_M 12
`define TMB_B_AINV2 6
// blend operation codes
`define TMB_OP_OFF 5'h00
`define TMB_OP_SEL1 5'h01
`define TMB_OP_SEL2 5'h02
`define TMB_OP_MOD 5'h03
`define TMB_OP_MOD2 5'h04
`define TMB_OP_MOD4 5'h05
`define TMB_OP_ADD 5'h06
`define TMB_OP_ADDS 5'h07
`define TMB_OP_LERPI 5'h08
`define TMB_OP_LERPF 5'h0A
`define TMB_OP_LERPA0 5'h10
`define TMB_OP_LERPA1 5'h11
`define TMB_OP_LERPC0 5'h12
`define TMB_OP_LERPC1 5'h13
`define TMB_OP_SUB 5'h14
// argument codes
`define TMB_ARG_ONES 3'h0
`define TMB_ARG_FAC 3'h1
`define TMB_ARG_ACC 3'h2
`define TMB_ARG_ITER 3'h3
`define TMB_ARG_SPEC 3'h4
`define TMB_ARG_CUR 3'h5
`define TMB_ARG_TEX0 3'h6
`define TMB_ARG_TEX1 3'h7
// source slots
`define TMB_SRC_FAC 0
`define TMB_SRC_ITER 1
`define TMB_SRC_SPEC 2
`define TMB_SRC_TEX0 3
`define TMB_SRC_TEX1 4
// arithmetic
`define TMB_RND 16'h0080
`define TMB_EXCESS 10'h080
// register byte offsets
`define TMB_A_CMD 8'h00
`define TMB_A_STATUS 8'h04
`define TMB_A_MAP0 8'h08
`define TMB_A_MAP1 8'h0C
`define TMB_A_STG0 8'h10
`define TMB_A_STG1 8'h14
`define TMB_A_STG2 8'h18
`define TMB_A_PIDX 8'h20
`define TMB_A_PDATA 8'h24
`define TMB_A_SRC0 8'h28
`define TMB_A_SRC4 8'h38
`define TMB_A_RUN 8'h3C
`define TMB_A_CUR 8'h40
`define TMB_A_ACC 8'h44
`define TMB_A_LODIN 8'h48
`define TMB_A_LODOUT 8'h4C
`endif

// >>> design/tmb_pkg.sv
`default_nettype none
package tmb_pkg;
	typedef struct packed {
		logic ani;
		logic [1:0] mip;
		logic mag;
		logic min;
		logic [7:0] maxl;
		logic [3:0] minl;
		logic [6:0] bias;
	} tmb_map_type;
	typedef struct packed {
		logic dst;
		logic [2:0] ca1;
		logic rep1;
		logic inv1;
		logic [2:0] ca2;
		logic rep2;
		logic inv2;
		logic [4:0] cop;
		logic [2:0] aa1;
		logic ainv1;
		logic [2:0] aa2;
		logic ainv2;
		logic [4:0] aop;
	} tmb_stg_type;
	typedef enum logic [0:0] {TMB_IDLE = 1'b0, TMB_RUN = 1'b1} tmb_run_type;
	typedef struct packed {
		tmb_map_type [1:0] map;
		tmb_stg_type [2:0] stg;
		logic pal_busy;
		logic [7:0] pal_cnt;
		logic [7:0] pal_idx;
		logic [4:0][31:0] src;
		logic [31:0] cur;
		logic [31:0] acc;
		tmb_run_type run;
		logic [1:0] sidx;
		logic [31:0] result;
		logic [7:0] lod;
		logic ack;
		logic [31:0] dat;
	} tmb_st_type;
endpackage
`default_nettype wire

// >>> design/tmb_blend_alu.sv
`include "tmb_defines.svh"
`default_nettype none
module tmb_blend_alu (
	input wire logic [31:0] arg1_i,
	input wire logic [31:0] arg2_i,
	input wire logic [31:0] cterm_i,
	input wire logic [7:0] aterm_i,
	input wire logic [4:0] cop_i,
	input wire logic [4:0] aop_i,
	output logic [31:0] res_o
);
	// a*b/255 with rounding, no divider
	function automatic logic [7:0] mul8(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] p;
		p = a * b;
		p = p + {8'h00, p[15:8]} + `TMB_RND;
		return p[15:8];
	endfunction

	function automatic logic [7:0] sat8(input logic [9:0] v);
		return (v > 10'h0FF) ? 8'hFF : v[7:0];
	endfunction

	// one 8-bit lane of a blend stage
	function automatic logic [7:0] op8(input logic [4:0] op, input logic [7:0] a,
			input logic [7:0] b, input logic [7:0] t);
		logic [9:0] m;
		logic [9:0] s;
		m = {2'b00, mul8(a, b)};
		s = {2'b00, a} + {2'b00, b};
		case (op)
			`TMB_OP_SEL1: op8 = a;
			`TMB_OP_SEL2: op8 = b;
			`TMB_OP_MOD: op8 = m[7:0];
			`TMB_OP_MOD2: op8 = sat8({m[8:0], 1'b0});
			`TMB_OP_MOD4: op8 = sat8({m[7:0], 2'b00});
			`TMB_OP_ADD: op8 = sat8(s);
			`TMB_OP_ADDS: op8 = (s < `TMB_EXCESS) ? 8'h00 : sat8(s - `TMB_EXCESS);
			`TMB_OP_LERPI, `TMB_OP_LERPF, `TMB_OP_LERPA0, `TMB_OP_LERPA1,
			`TMB_OP_LERPC0, `TMB_OP_LERPC1: op8 = sat8({2'b00, mul8(t, a)} + {2'b00, mul8(~t, b)});
			`TMB_OP_SUB: op8 = (a > b) ? a - b : 8'h00;
			default: op8 = a;
		endcase
	endfunction

	// alpha lane uses the alpha operation, colour lanes the colour one
	assign res_o = {op8(aop_i, arg1_i[31:24], arg2_i[31:24], aterm_i),
		op8(cop_i, arg1_i[23:16], arg2_i[23:16], cterm_i[23:16]),
		op8(cop_i, arg1_i[15:8], arg2_i[15:8], cterm_i[15:8]),
		op8(cop_i, arg1_i[7:0], arg2_i[7:0], cterm_i[7:0])};
endmodule
`default_nettype wire

// >>> tb/tmb_host_model.sv
`default_nettype none
// wishbone master standing in for the driver command stream
module tmb_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] rdat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int timeouts = 0;
	// idle bus from time zero
	initial begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = 47'h0;
	end
	// one classic cycle, request held until ack is sampled high or 32 clocks pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_o <= 1'h1;
		stb_o <= 1'h1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'h1 && n < 32);
		if (ack_i !== 1'h1)
			timeouts++;
		r = rdat_i;
		cyc_o <= 1'h0;
		stb_o <= 1'h0;
		// released data bus shows the inverse, not the last value
		dat_o <= ~d;
	endtask
endmodule
`default_nettype wire

// >>> tb/texture_map_state_and_blend_stages_tb_top.sv
`include "tmb_defines.svh"
`default_nettype none
module texture_map_state_and_blend_stages_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic cyc, stb, we, ack, busy, inv;
	logic [3:0] sel;
	logic [7:0] adr, lod;
	logic [31:0] wdat, rdat, result, q, f, e;
	logic [2:0] cl;
	logic [4:0] op, aop;
	logic ani [2], mag [2], mn [2];
	logic [1:0] mip [2];
	logic [7:0] maxl [2];
	logic [3:0] minl [2];
	logic [6:0] bias [2];
	logic [15:0] pal [256];
	logic [31:0] src [5];
	logic [4:0] ops [6] = '{5'h01, 5'h02, 5'h06, 5'h07, 5'h14, 5'h01};
	int mismatches = 0;
	int comparisons = 0;
	int seed = 27468;
	int i, k, m, n;
	// 125 MHz clock
	always #4 clk = ~clk;
	tmb_top dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .ack_o(ack), .dat_o(rdat), .result_o(result), .lod_o(lod), .busy_o(busy));
	tmb_host_model host_u (.clk_i(clk), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat));
	////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'h1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		host_u.xfer(1'h0, a, 32'h0, q);
	endtask
	// map register image as the bench expects it
	function automatic logic [31:0] mapv(input int j);
		return {8'h00, ani[j], mip[j], mag[j], mn[j], maxl[j], minl[j], bias[j]};
	endfunction
	// biased lod, clamped to a byte, then to the max and min levels
	function automatic logic [7:0] lodx(input int j, input logic [7:0] raw);
		int s;
		s = int'(raw) + int'($signed(bias[j]));
		if (s < 0)
			s = 0;
		if (s > 255)
			s = 255;
		if (maxl[j] != 8'h00 && s < int'(maxl[j]))
			s = maxl[j];
		if (s > int'(minl[j]) * 16)
			s = int'(minl[j]) * 16;
		return 8'(s);
	endfunction
	// one channel of a blend operation, saturating
	function automatic logic [7:0] fop(input logic [4:0] o, input int a, input int b);
		int s;
		case (o)
			5'h02: s = b;
			5'h06: s = a + b;
			5'h07: s = a + b - 128;
			5'h14: s = a - b;
			default: s = a;
		endcase
		if (s < 0)
			s = 0;
		if (s > 255)
			s = 255;
		return 8'(s);
	endfunction
	task automatic run_walk(input logic [31:0] exp);
		wr(`TMB_A_RUN, 32'h0);
		n = 0;
		while (busy !== 1'h0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
			mismatches++;
		chk("result_o", result, exp);
	endtask
	task automatic close_out;
		mismatches += host_u.timeouts;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		for (m = 0; m < 2; m++) begin
			{ani[m], mip[m], mag[m], mn[m], maxl[m], bias[m]} = 20'h0;
			minl[m] = 4'hA;
		end
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		rd(`TMB_A_MAP0);
		chk("map0", q, mapv(0));
		rd(`TMB_A_STG1);
		chk("stg1", q, 32'h0);
		rd(8'h7C);
		chk("unmapped", q, 32'h0);
		// random map commands, every fifth with a foreign client code
		for (i = 0; i < 30; i++) begin
			m = $random(seed) & 1;
			f = $random(seed);
			op = 5'(2 + i % 3);
			cl = (i % 5 == 4) ? 3'h2 : 3'h3;
			wr(`TMB_A_CMD, {cl, 5'h1C, op, 2'h0, m[0], f[15:0]});
			if (cl == 3'h3) begin
				case (op)
					5'h02: begin
						if (f[12])
							ani[m] = f[10];
						if (f[9] && !f[7])
							mip[m] = f[7:6];
						if (f[5])
							mag[m] = f[3];
						if (f[2])
							mn[m] = f[0];
					end
					5'h03: begin
						if (f[13])
							maxl[m] = f[12:5];
						if (f[4] && f[3:0] <= 4'hA)
							minl[m] = f[3:0];
					end
					default: if (f[7])
						bias[m] = f[6:0];
				endcase
			end
			rd(m ? `TMB_A_MAP1 : `TMB_A_MAP0);
			chk("map", q, mapv(m));
		end
		// legal limits with max below min, then lod requests on both maps
		for (m = 0; m < 2; m++) begin
			k = $random(seed) & 3;
			minl[m] = 4'(7 + k);
			maxl[m] = {4'(k + 1), 4'($random(seed))};
			wr(`TMB_A_CMD, {3'h3, 5'h1C, 5'h03, 2'h0, m[0], 2'h0, 1'h1, maxl[m], 1'h1, minl[m]});
		end
		for (i = 0; i < 24; i++) begin
			m = i & 1;
			f = $random(seed);
			wr(`TMB_A_LODIN, {23'h0, m[0], f[7:0]});
			rd(`TMB_A_LODOUT);
			chk("lodout", q, {24'h0, lodx(m, f[7:0])});
			chk("lod_o", {24'h0, lod}, {24'h0, lodx(m, f[7:0])});
		end
		// palette load with random reserved halves, then read back
		wr(`TMB_A_CMD, 32'h7D8200FF);
		rd(`TMB_A_STATUS);
		chk("pal_busy", q & 32'h1, 32'h1);
		for (k = 0; k < 256; k++) begin
			f = $random(seed);
			pal[k] = f[15:0];
			wr(`TMB_A_CMD, f);
		end
		rd(`TMB_A_STATUS);
		chk("pal_done", q & 32'h1, 32'h0);
		for (i = 0; i < 6; i++) begin
			k = (i < 2) ? i * 255 : ($random(seed) & 255);
			wr(`TMB_A_PIDX, 32'(k));
			rd(`TMB_A_PDATA);
			chk("palette", q, {16'h0, pal[k]});
		end
		// stage 0 on texel0 and texel1, alpha stage programmed alike
		for (k = 0; k < 5; k++) begin
			src[k] = $random(seed);
			wr(8'(`TMB_A_SRC0 + 4 * k), src[k]);
		end
		for (i = 0; i < 6; i++) begin
			op = ops[i];
			inv = (i == 5);
			wr(`TMB_A_CMD, {3'h3, 5'h00, 4'h0, 3'h5, 3'h6, 1'h0, inv, 1'h1, 3'h7, 3'h1, op});
			wr(`TMB_A_CMD, {3'h3, 5'h01, 4'h0, 2'h1, 3'h6, 1'h0, inv, 2'h2, 3'h7, 3'h1, op});
			// alpha op 14h is reserved, so the alpha lane keeps the last legal op
			if (op != 5'h14)
				aop = op;
			for (k = 0; k < 4; k++)
				e[8*k +: 8] = fop((k == 3) ? aop : op, int'(src[3][8*k +: 8] ^ {8{inv}}), int'(src[4][8*k +: 8]));
			run_walk(e);
		end
		// stage 0 into the accumulator, stage 1 adds accumulator and current
		wr(`TMB_A_CMD, {3'h3, 5'h00, 4'h0, 2'h3, 18'h0});
		wr(`TMB_A_CMD, {3'h3, 5'h00, 2'h0, 2'h1, 3'h5, 3'h2, 2'h0, 1'h1, 3'h5, 3'h1, 5'h06});
		wr(`TMB_A_CMD, {3'h3, 5'h01, 2'h0, 2'h1, 1'h0, 1'h1, 3'h5, 9'h0, 1'h1, 5'h01});
		e[31:24] = src[1][31:24];
		for (k = 0; k < 3; k++)
			e[8*k +: 8] = fop(5'h06, int'(src[3][8*k +: 8] ^ 8'hFF), int'(src[1][8*k +: 8]));
		run_walk(e);
		rd(`TMB_A_ACC);
		chk("acc", q, ~src[3]);
		// disabled stage 0 leaves the seeded iterated colour
		wr(`TMB_A_CMD, {3'h3, 5'h00, 18'h0, 1'h1, 5'h00});
		run_walk(src[1]);
		close_out();
	end
endmodule
`default_nettype wire
